/* hdl/cmb_pkg.sv */
package cmb_pkg;
   localparam int NMB     = 4;
   localparam int MBW     = 2;
   localparam int TS_W    = 16;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_STAT  = 8'h04;
   localparam logic [7:0] OFS_IEN   = 8'h08;
   localparam logic [7:0] OFS_TIMER = 8'h0C;
   localparam logic [7:0] OFS_MASK  = 8'h10;
   localparam logic [7:0] OFS_STATE = 8'h14;
   // mailbox window: bit 7 set, index in bits 5:4, word in bits 3:2
   localparam int MB_SEL_BIT = 7;
   localparam int MB_IDX_LSB = 4;
   localparam int WD_LSB     = 2;
   localparam logic [1:0] WD_ZERO = 2'h0;
   localparam logic [1:0] WD_ONE  = 2'h1;
   localparam logic [1:0] WD_DATA = 2'h2;

   // descriptor word zero fields
   localparam int CODE_LSB = 24;
   localparam int FDF_BIT  = 29;
   localparam int IDE_BIT  = 21;
   localparam int RTR_BIT  = 20;
   localparam int DLC_LSB  = 16;
   // control register bits
   localparam int CTRL_PERMIT_BIT = 0;
   // state register fields
   localparam int ST_PEND_LSB = 4;
   localparam int ST_LOCK_BIT = 8;
   localparam int ST_LIDX_LSB = 9;

   localparam logic [31:0] MASK_RST = 32'h1FFF_FFFF;

   typedef enum logic [3:0] {
      CODE_RX_INACTIVE = 4'h0,
      CODE_RX_FULL     = 4'h2,
      CODE_RX_EMPTY    = 4'h4,
      CODE_RX_OVERRUN  = 4'h6,
      CODE_TX_INACTIVE = 4'h8,
      CODE_TX_ABORT    = 4'h9,
      CODE_TX_DATA     = 4'hC
   } cmb_code_e;

   typedef struct packed {
      logic [28:0] id;
      logic        fdf;
      logic        ide;
      logic        rtr;
      logic [3:0]  dlc;
      logic [31:0] data;
   } cmb_frame_s;
endpackage

/* hdl/cmb_mailbox.sv */
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
module cmb_mailbox (
   // clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // ahb-lite slave
   input  wire logic                 hsel_i,
   input  wire logic [31:0]          haddr_i,
   input  wire logic [1:0]           htrans_i,
   input  wire logic                 hwrite_i,
   input  wire logic [2:0]           hsize_i,
   input  wire logic [31:0]          hwdata_i,
   input  wire logic                 hready_i,
   output logic      [31:0]          hrdata_o,
   output logic                      hreadyout_o,
   output logic                      hresp_o,
   // protocol engine, transmit side
   input  wire logic                 arb_win_valid_i,
   input  wire logic [cmb_pkg::MBW-1:0] arb_win_idx_i,
   input  wire logic                 intermission_start_i,
   input  wire logic                 bus_idle_i,
   input  wire logic                 wait_bus_idle_i,
   input  wire logic                 tx_ok_i,
   input  wire logic                 arb_lost_i,
   input  wire logic                 tx_error_i,
   input  wire logic                 overload_i,
   input  wire logic                 bus_off_i,
   input  wire logic                 inactive_i,
   output cmb_pkg::cmb_frame_s       tx_frame_o,
   output logic                      tx_frame_valid_o,
   output logic      [cmb_pkg::MBW-1:0] tx_frame_idx_o,
   // protocol engine, receive side
   input  wire logic                 rx_id_bit2_i,
   input  wire logic                 rx_done_i,
   input  wire cmb_pkg::cmb_frame_s  rx_frame_i,
   input  wire logic                 low_power_state_flag_i,
   output logic                      rx_fifo_req_o,
   // interrupt
   output logic                      mb_irq_o
);
   import cmb_pkg::*;

   logic [31:0]     mb_w0 [NMB];
   logic [31:0]     mb_w1 [NMB];
   logic [31:0]     mb_w2 [NMB];
   logic [31:0]     ctrl, ien, mask;
   logic [NMB-1:0]  flags, blocked, abort_pend;
   logic [TS_W-1:0] timer, ts_cap, rxb_ts;
   logic            wr_cmt, sh_valid, lock_valid, rxb_valid, bus_off_q;
   logic [7:0]      w_addr;
   logic [MBW-1:0]  sh_idx, lock_idx, rxb_idx;
   cmb_frame_s      rxb;

   function automatic logic [3:0] code_of(input logic [31:0] w0);
      return w0[CODE_LSB +: 4];
   endfunction

   function automatic logic [31:0] mk_w0(input logic [3:0] code, input cmb_frame_s f,
                                         input logic [TS_W-1:0] ts);
      logic [31:0] w;
      w = '0;
      w[CODE_LSB +: 4] = code;
      w[FDF_BIT]       = f.fdf;
      w[IDE_BIT]       = f.ide;
      w[RTR_BIT]       = f.rtr;
      w[DLC_LSB +: 4]  = f.dlc;
      w[TS_W-1:0]      = ts;
      return w;
   endfunction

   function automatic logic is_full(input logic [3:0] code);
      return code == CODE_RX_FULL || code == CODE_RX_OVERRUN;
   endfunction

   // bus decode
   logic           ap_rd, ap_wr, w_is_mb, w0_req, abort_req, abort_now, pend_set, w0_we;
   logic           cpu_mb_acc, tx_fail_ev, tx_ok_ev, shift_go, rx_store, deact, rx_live;
   logic [MBW-1:0] w_idx, a_idx;
   logic [1:0]     w_wd;
   logic [3:0]     code_w;
   logic [NMB-1:0] stat_clr, flag_set;

   assign ap_rd   = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   assign ap_wr   = hsel_i && hready_i && htrans_i[1] && hwrite_i;
   assign a_idx   = haddr_i[MB_IDX_LSB +: MBW];
   assign w_is_mb = wr_cmt && w_addr[MB_SEL_BIT];
   assign w_idx   = w_addr[MB_IDX_LSB +: MBW];
   assign w_wd    = w_addr[WD_LSB +: 2];
   assign code_w  = hwdata_i[CODE_LSB +: 4];
   assign w0_req  = w_is_mb && w_wd == WD_ZERO;
   // abort only counts under write permit; software keeps to that
   assign abort_req = w0_req && code_w == CODE_TX_ABORT
                      && ctrl[CTRL_PERMIT_BIT];
   assign w0_we     = w0_req && !blocked[w_idx];
   assign abort_now = abort_req && !blocked[w_idx];
   assign pend_set  = abort_req && blocked[w_idx];
   assign deact     = w0_we && (code_w == CODE_RX_INACTIVE || code_w == CODE_TX_INACTIVE
                      || code_w == CODE_TX_ABORT);
   assign cpu_mb_acc = w_is_mb || ((ap_rd || ap_wr) && haddr_i[MB_SEL_BIT]);
   assign stat_clr  = (wr_cmt && w_addr == OFS_STAT) ? hwdata_i[NMB-1:0] : '0;

   assign tx_ok_ev   = sh_valid && tx_ok_i;
   assign tx_fail_ev = sh_valid && (arb_lost_i || tx_error_i || overload_i
                       || (bus_off_i && !bus_off_q));
   // shift-out yields to any processor access to mailbox memory
   assign shift_go = arb_win_valid_i && !sh_valid && !cpu_mb_acc
                     && code_of(mb_w0[arb_win_idx_i]) == CODE_TX_DATA
                     && (intermission_start_i || bus_idle_i || wait_bus_idle_i);
   assign rx_store = rxb_valid && !low_power_state_flag_i && !cpu_mb_acc
                     && !(lock_valid && lock_idx == rxb_idx);
   // a mailbox deactivated after matching silently drops the buffered frame
   assign rx_live  = rx_store && (is_full(code_of(mb_w0[rxb_idx]))
                     || code_of(mb_w0[rxb_idx]) == CODE_RX_EMPTY);

   always_comb begin
      flag_set = '0;
      if (abort_now)
         flag_set[w_idx] = 1'b1;
      if (tx_ok_ev)
         flag_set[sh_idx] = 1'b1;
      if (tx_fail_ev && abort_pend[sh_idx])
         flag_set[sh_idx] = 1'b1;
      if (rx_live)
         flag_set[rxb_idx] = 1'b1;
   end

   // receive matching, lowest index wins
   logic           m_hit;
   logic [MBW-1:0] m_idx;
   always_comb begin
      logic [3:0] c;
      c     = '0;
      m_hit = 1'b0;
      m_idx = '0;
      for (int i = NMB - 1; i >= 0; i--) begin
         c = code_of(mb_w0[i]);
         if ((c == CODE_RX_EMPTY || is_full(c))
             && ((mb_w1[i][28:0] ^ rx_frame_i.id) & mask[28:0]) == '0
             && mb_w0[i][IDE_BIT] == rx_frame_i.ide
             && mb_w0[i][RTR_BIT] == rx_frame_i.rtr) begin
            m_hit = 1'b1;
            m_idx = MBW'(i);
         end
      end
   end

   // ahb slave: writes commit in one stall cycle, reads answer with zero wait
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_cmt   <= 1'b0;
         w_addr   <= '0;
         hrdata_o <= '0;
      end else begin
         wr_cmt <= ap_wr;
         if (ap_wr)
            w_addr <= haddr_i[7:0];
         if (ap_rd) begin
            if (haddr_i[MB_SEL_BIT]) begin
               case (haddr_i[WD_LSB +: 2])
                  WD_ZERO: hrdata_o <= mb_w0[a_idx];
                  WD_ONE:  hrdata_o <= mb_w1[a_idx];
                  WD_DATA: hrdata_o <= mb_w2[a_idx];
                  default: hrdata_o <= '0;
               endcase
            end else begin
               case (haddr_i[7:0])
                  OFS_CTRL:  hrdata_o <= ctrl;
                  OFS_STAT:  hrdata_o <= 32'(flags);
                  OFS_IEN:   hrdata_o <= ien;
                  OFS_TIMER: hrdata_o <= 32'(timer);
                  OFS_MASK:  hrdata_o <= mask;
                  OFS_STATE: hrdata_o <= 32'({lock_idx, lock_valid, abort_pend, blocked});
                  default:   hrdata_o <= '0;
               endcase
            end
         end
      end
   end
   assign hreadyout_o = !wr_cmt;
   assign hresp_o     = 1'b0;

   // software registers
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ctrl <= '0;
         ien  <= '0;
         mask <= MASK_RST;
      end else if (wr_cmt) begin
         if (w_addr == OFS_CTRL)
            ctrl <= hwdata_i;
         if (w_addr == OFS_IEN)
            ien <= hwdata_i;
         if (w_addr == OFS_MASK)
            mask <= hwdata_i;
      end
   end

   // status flags: set beats clear
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i)
         flags <= '0;
      else
         flags <= (flags & ~stat_clr) | flag_set;
   end
   assign mb_irq_o = |(flags & ien[NMB-1:0]);

   // free-running counter and timestamp capture
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         timer  <= '0;
         ts_cap <= '0;
      end else begin
         timer <= timer + 1'b1;
         if (rx_id_bit2_i)
            ts_cap <= timer;
      end
   end

   // mailbox memory
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NMB; i++) begin
            mb_w0[i] <= '0;
            mb_w1[i] <= '0;
            mb_w2[i] <= '0;
         end
      end else begin
         if (w0_we)
            mb_w0[w_idx] <= hwdata_i;
         if (w_is_mb && w_wd == WD_ONE)
            mb_w1[w_idx] <= hwdata_i;
         if (w_is_mb && w_wd == WD_DATA)
            mb_w2[w_idx] <= hwdata_i;
         if (rx_live) begin
            mb_w0[rxb_idx] <= mk_w0(flags[rxb_idx] ? CODE_RX_OVERRUN : CODE_RX_FULL,
                                    rxb, rxb_ts);
            mb_w1[rxb_idx] <= 32'(rxb.id);
            mb_w2[rxb_idx] <= rxb.data;
         end
         if (tx_ok_ev)
            mb_w0[sh_idx] <= {mb_w0[sh_idx][31:28], CODE_TX_INACTIVE,
                              mb_w0[sh_idx][23:TS_W], timer};
         if (tx_fail_ev && abort_pend[sh_idx])
            mb_w0[sh_idx][CODE_LSB +: 4] <= CODE_TX_ABORT;
      end
   end

   // shift-out into the transmit shift buffer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sh_valid   <= 1'b0;
         sh_idx     <= '0;
         tx_frame_o <= '0;
      end else if (shift_go) begin
         sh_valid   <= 1'b1;
         sh_idx     <= arb_win_idx_i;
         tx_frame_o <= '{id:   mb_w1[arb_win_idx_i][28:0],
                         fdf:  mb_w0[arb_win_idx_i][FDF_BIT],
                         ide:  mb_w0[arb_win_idx_i][IDE_BIT],
                         rtr:  mb_w0[arb_win_idx_i][RTR_BIT],
                         dlc:  mb_w0[arb_win_idx_i][DLC_LSB +: 4],
                         data: mb_w2[arb_win_idx_i]};
      end else if (tx_ok_ev || tx_fail_ev) begin
         sh_valid <= 1'b0;
      end
   end
   assign tx_frame_valid_o = sh_valid;
   assign tx_frame_idx_o   = sh_idx;

   // descriptor word zero write blocking and pending aborts
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         blocked    <= '0;
         abort_pend <= '0;
         bus_off_q  <= 1'b0;
      end else begin
         bus_off_q <= bus_off_i;
         for (int i = 0; i < NMB; i++) begin
            if (shift_go && arb_win_idx_i == MBW'(i))
               blocked[i] <= 1'b1;
            if ((tx_fail_ev && sh_idx == MBW'(i)) || inactive_i || bus_off_i
                || (stat_clr[i] && !flag_set[i] && !(sh_valid && sh_idx == MBW'(i))
                    && code_of(mb_w0[i]) == CODE_TX_INACTIVE))
               blocked[i] <= 1'b0;
            if (pend_set && w_idx == MBW'(i))
               abort_pend[i] <= 1'b1;
            if ((tx_ok_ev || tx_fail_ev) && sh_idx == MBW'(i))
               abort_pend[i] <= 1'b0;
         end
      end
   end

   // receive shift buffer; a newer frame simply overwrites it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rxb_valid     <= 1'b0;
         rxb           <= '0;
         rxb_ts        <= '0;
         rxb_idx       <= '0;
         rx_fifo_req_o <= 1'b0;
      end else begin
         rx_fifo_req_o <= rx_done_i && !m_hit && !rx_frame_i.fdf;
         if (rx_done_i && m_hit) begin
            rxb_valid <= 1'b1;
            rxb       <= rx_frame_i;
            rxb_ts    <= ts_cap;
            rxb_idx   <= m_idx;
         end else if (rx_store) begin
            rxb_valid <= 1'b0;
         end
      end
   end

   // receive mailbox lock
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         lock_valid <= 1'b0;
         lock_idx   <= '0;
      end else if (deact && lock_idx == w_idx) begin
         lock_valid <= 1'b0;
      end else if (ap_rd && haddr_i[7:0] == OFS_TIMER) begin
         lock_valid <= 1'b0;
      end else if (ap_rd && haddr_i[MB_SEL_BIT] && haddr_i[WD_LSB +: 2] == WD_ZERO) begin
         lock_valid <= is_full(code_of(mb_w0[a_idx]));
         lock_idx   <= a_idx;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_abort_blocked;
      pend_set ##1 (sh_valid && !tx_ok_ev && !tx_fail_ev);
   endsequence

   a_shiftout_blocks: assert property (shift_go |=> sh_valid && blocked[sh_idx])
      else $error("shift-out did not load and block the mailbox");
   a_write_refused: assert property (w0_req && blocked[w_idx] |=>
         mb_w0[$past(w_idx)] == $past(mb_w0[w_idx]) || $past(tx_ok_ev || tx_fail_ev))
      else $error("blocked word zero was written");
   a_fail_restores: assert property (tx_fail_ev |=> !blocked[$past(sh_idx)])
      else $error("write access not restored after failure");
   a_start_window: assert property (shift_go |->
         intermission_start_i || bus_idle_i || wait_bus_idle_i)
      else $error("shift-out outside the allowed bus states");
   a_cpu_first: assert property (cpu_mb_acc |=> !sh_valid || $past(sh_valid))
      else $error("shift-out beat a processor access");
   a_abort_now: assert property (abort_now |=> flags[$past(w_idx)]
         && code_of(mb_w0[$past(w_idx)]) == CODE_TX_ABORT)
      else $error("immediate abort missing flag or code");
   a_abort_held: assert property (s_abort_blocked |-> abort_pend[$past(w_idx)])
      else $error("pending abort lost before frame end");
   a_ok_drops: assert property (tx_ok_ev |=> !abort_pend[$past(sh_idx)]
         && flags[$past(sh_idx)] && code_of(mb_w0[$past(sh_idx)]) == CODE_TX_INACTIVE)
      else $error("success did not drop abort and set flag");
   a_fail_abort: assert property (tx_fail_ev && abort_pend[sh_idx] |=>
         code_of(mb_w0[$past(sh_idx)]) == CODE_TX_ABORT && flags[$past(sh_idx)])
      else $error("failed frame with pending abort not aborted");
   a_fd_no_fifo: assert property (rx_done_i && rx_frame_i.fdf |=> !rx_fifo_req_o)
      else $error("flexible-rate frame sent toward fifo");
   a_ts_capture: assert property (rx_done_i && m_hit |=> rxb_ts == $past(ts_cap))
      else $error("timestamp not taken from identifier capture");
   a_lock_holds: assert property (lock_valid && rxb_valid && lock_idx == rxb_idx
         |-> !rx_store)
      else $error("locked mailbox was overwritten");
   a_lps_delay: assert property (low_power_state_flag_i |-> !rx_store)
      else $error("shift-in during low power state");
   a_deact_unlock: assert property (deact && lock_valid && lock_idx == w_idx
         |=> !lock_valid)
      else $error("deactivation left the mailbox locked");
   a_flag_sticky: assert property (stat_clr == '0 |=> ($past(flags) & ~flags) == '0)
      else $error("status flag fell without a clear");
endmodule

/* bench/cmb_bus_node.sv */
`timescale 1ns/1ps
module cmb_bus_node (
   input  wire logic                    clk_i,
   input  wire logic                    tx_valid_i,
   output logic                         win_o,
   output logic     [cmb_pkg::MBW-1:0]  win_idx_o,
   output logic     [2:0]               start_o,
   output logic     [4:0]               end_o,
   output logic                         bit2_o,
   output logic                         done_o,
   output cmb_pkg::cmb_frame_s          frame_o
);
   import cmb_pkg::*;
   initial begin
      {win_o, win_idx_o, start_o, end_o, bit2_o, done_o} = '0;
      frame_o = '0;
   end
   // hold the winner until the shift buffer reports it taken
   // s picks the start window: 0 intermission, 1 bus idle, 2 waiting for idle
   task automatic win(input logic [1:0] i, input int s, output bit ok);
      int n;
      win_o     <= 1'b1;
      win_idx_o <= i;
      start_o   <= 3'h1 << s;
      for (n = 0; n < 50 && tx_valid_i !== 1'b1; n++) @(posedge clk_i);
      ok = (tx_valid_i === 1'b1);
      win_o   <= 1'b0;
      start_o <= '0;
   endtask
   // 0 sent, 1 arbitration lost, 2 error, 3 overload, 4 bus-off
   task automatic fin(input int k);
      end_o <= 5'h01 << k;
      @(posedge clk_i);
      end_o <= '0;
   endtask
   task automatic recv(input cmb_frame_s f);
      bit2_o <= 1'b1;
      @(posedge clk_i);
      bit2_o  <= 1'b0;
      frame_o <= f;
      done_o  <= 1'b1;
      @(posedge clk_i);
      done_o  <= 1'b0;
      frame_o <= ~f;
      repeat (3) @(posedge clk_i);
   endtask
endmodule

/* bench/test_can_mailbox_shiftout_abort_rx_lock.sv */
`timescale 1ns/1ps
module test_can_mailbox_shiftout_abort_rx_lock;
   import cmb_pkg::*;
   logic        clk_i = 0, resetn_i = 0, hwrite = 0, low_power_state_flag = 0, hready, tx_v, irq;
   logic [1:0]  htrans = 0, tx_idx, widx;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, seed = 32'h0000_4f31;
   logic        win, bit2, done, hresp, fifo_req, inact = 0;
   logic [2:0]  start;
   logic [4:0]  fin;
   cmb_frame_s  tx_f, rf, f;
   int          error_cnt = 0, n_checks = 0, fifo_cnt = 0;
   bit          ok;
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i)
      if (fifo_req === 1'b1) fifo_cnt <= fifo_cnt + 1;
   cmb_mailbox DUT (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .arb_win_valid_i(win), .arb_win_idx_i(widx), .intermission_start_i(start[0]),
      .bus_idle_i(start[1]), .wait_bus_idle_i(start[2]), .tx_ok_i(fin[0]),
      .arb_lost_i(fin[1]), .tx_error_i(fin[2]), .overload_i(fin[3]), .bus_off_i(fin[4]),
      .inactive_i(inact),
      .tx_frame_o(tx_f), .tx_frame_valid_o(tx_v), .tx_frame_idx_o(tx_idx),
      .rx_id_bit2_i(bit2), .rx_done_i(done), .rx_frame_i(rf),
      .low_power_state_flag_i(low_power_state_flag), .rx_fifo_req_o(fifo_req), .mb_irq_o(irq));
   cmb_bus_node node (.clk_i(clk_i), .tx_valid_i(tx_v), .win_o(win), .win_idx_o(widx),
      .start_o(start), .end_o(fin), .bit2_o(bit2), .done_o(done), .frame_o(rf));
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
   endfunction
   function automatic logic [31:0] mb(int i, int w);
      return 32'h0000_0080 + 32'(16 * i + 4 * w);
   endfunction
   function automatic logic [31:0] cw(cmb_code_e c);
      return {4'h0, c, 24'h00_0000};
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic xfer(bit w, logic [31:0] a, logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) n = 100;
      htrans <= 2'b00;
      hwdata <= d;
      do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 100);
      rd = hrdata;
      chk("hresp", 0, {31'h0, hresp});
      if (n >= 100) begin
         error_cnt++;
         final_report();
      end
   endtask
   initial begin
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      chk("irq", 0, irq);
      chk("txv", 0, tx_v);
      xfer(0, OFS_MASK, 0);
      chk("mask", MASK_RST, rd);
      xfer(0, 32'h0000_0040, 0);
      chk("unmapped", 0, rd);
      xfer(1, OFS_IEN, 32'h0000_000F);
      for (int k = 0; k < 5; k++) begin
         seed = lfsr(seed);
         xfer(1, OFS_CTRL, 0);
         xfer(1, mb(0, 1), {3'h0, seed[28:0]});
         xfer(1, mb(0, 2), seed);
         xfer(1, mb(0, 0), cw(CODE_TX_DATA));
         node.win(2'h0, k % 3, ok);
         chk("shiftout", 1, 32'(ok));
         chk("txdata", seed, tx_f.data);
         chk("txid", {3'h0, seed[28:0]}, {3'h0, tx_f.id});
         chk("txidx", 0, {30'h0, tx_idx});
         xfer(1, mb(0, 0), 0);
         xfer(0, mb(0, 0), 0);
         chk("blocked", CODE_TX_DATA, {28'h0, rd[27:24]});
         xfer(1, OFS_CTRL, 1);
         xfer(1, mb(0, 0), cw(CODE_TX_ABORT));
         xfer(0, OFS_STATE, 0);
         chk("pending", 1, {31'h0, rd[ST_PEND_LSB]});
         node.fin(k);
         repeat (2) @(posedge clk_i);
         chk("irq", 1, {31'h0, irq});
         xfer(0, mb(0, 0), 0);
         chk("code", k == 0 ? CODE_TX_INACTIVE : CODE_TX_ABORT, {28'h0, rd[27:24]});
         xfer(0, OFS_STATE, 0);
         chk("dropped", 0, {31'h0, rd[ST_PEND_LSB]});
         xfer(1, OFS_STAT, 0);
         xfer(0, OFS_STAT, 0);
         chk("flag", 1, {31'h0, rd[0]});
         xfer(1, OFS_STAT, 1);
         xfer(1, mb(0, 0), 0);
         xfer(0, mb(0, 0), 0);
         chk("reopen", 0, {28'h0, rd[27:24]});
      end
      xfer(1, mb(1, 0), cw(CODE_TX_DATA));
      xfer(1, mb(1, 0), cw(CODE_TX_ABORT));
      xfer(0, mb(1, 0), 0);
      chk("abort", CODE_TX_ABORT, {28'h0, rd[27:24]});
      xfer(0, OFS_STAT, 0);
      chk("abortflag", 1, {31'h0, rd[1]});
      xfer(1, mb(3, 0), cw(CODE_TX_DATA));
      node.win(2'h3, 1, ok);
      chk("shift3", 1, 32'(ok));
      xfer(0, OFS_STATE, 0);
      chk("blk3", 1, {31'h0, rd[3]});
      inact <= 1'b1;
      @(posedge clk_i);
      inact <= 1'b0;
      xfer(0, OFS_STATE, 0);
      chk("inactive", 0, {31'h0, rd[3]});
      node.fin(1);
      seed = lfsr(seed);
      xfer(1, OFS_STAT, 32'h0000_000F);
      xfer(1, mb(2, 1), {3'h0, seed[28:0]});
      xfer(1, mb(2, 0), cw(CODE_RX_EMPTY));
      f = '{id: seed[28:0], fdf: 1'b1, ide: 1'b0, rtr: 1'b0, dlc: 4'h4, data: seed};
      node.recv(f);
      xfer(0, mb(2, 0), 0);
      chk("full", CODE_RX_FULL, {28'h0, rd[27:24]});
      xfer(0, mb(2, 2), 0);
      chk("rxdata", seed, rd);
      xfer(0, OFS_STAT, 0);
      chk("rxflag", 1, {31'h0, rd[2]});
      f.data = ~seed;
      node.recv(f);
      xfer(0, mb(2, 2), 0);
      chk("locked", seed, rd);
      low_power_state_flag <= 1'b1;
      xfer(0, OFS_TIMER, 0);
      repeat (4) @(posedge clk_i);
      xfer(0, mb(2, 2), 0);
      chk("lowpower", seed, rd);
      low_power_state_flag <= 1'b0;
      repeat (4) @(posedge clk_i);
      xfer(0, mb(2, 2), 0);
      chk("unlocked", ~seed, rd);
      xfer(0, mb(2, 0), 0);
      chk("overrun", CODE_RX_OVERRUN, {28'h0, rd[27:24]});
      xfer(0, OFS_STATE, 0);
      chk("lock", 32'h0000_0005, {29'h0, rd[ST_LIDX_LSB +: 2], rd[ST_LOCK_BIT]});
      xfer(1, mb(2, 0), 0);
      xfer(0, OFS_STATE, 0);
      chk("deactivate", 0, {31'h0, rd[ST_LOCK_BIT]});
      node.recv(f);
      chk("fdfifo", 0, fifo_cnt);
      f.fdf = 1'b0;
      node.recv(f);
      chk("cfifo", 1, fifo_cnt);
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end
endmodule
